// >>> rsd_datapath.sv
// Rotate and subtract-with-borrow datapath with an AXI4-Lite register slave
//
// The placing of the registers and the AXI4-Lite interface to the registers were chosen for this implementation.
`timescale 1ns/100ps
// Overview of operation
// RULE_01: Left rotate through carry to accumulator; memory bit 7 to carry, memory kept.
// RULE_02: In-place right rotate, bit 0 into bit 7, no flag changes.
// RULE_03: Right rotate into accumulator, bit 0 into bit 7; memory and flags kept.
// RULE_04: In-place right rotate through carry; old carry to bit 7, bit 0 to carry.
// RULE_05: Right rotate through carry into accumulator; memory kept, only carry changes.
// RULE_06: Accumulator becomes accumulator minus memory minus inverted carry.
// RULE_07: After subtract, carry clear on negative result, set on zero or positive.
// RULE_08: Subtract updates overflow, zero, aux carry, carry, signed cascade, cascade zero.
// RULE_09: Flags not affected by an operation keep their previous value.
module rsd_datapath (
   input  wire logic        aclk,
   input  wire logic        aresetn,
   input  wire logic [4:0]  s_axi_awaddr,
   input  wire logic [2:0]  s_axi_awprot,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [4:0]  s_axi_araddr,
   input  wire logic [2:0]  s_axi_arprot,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready
);
   import rsd_pkg::*;

   ////////////////////////////////////////////////////////////////////////////////
   // State
   logic [7:0]     mem_reg;
   logic [7:0]     accumulator_reg;
   rsd_flags_type  flags_reg;
   logic [2:0]     op_reg;
   logic           exec_reg;
   logic [15:0]    count_reg;
   logic           bvalid_reg;
   logic [1:0]     bresp_reg;
   logic           rvalid_reg;
   logic [1:0]     rresp_reg;
   logic [31:0]    rdata_reg;

   ////////////////////////////////////////////////////////////////////////////////
   // Write channel decode: address and data are taken together
   wire        wr_take     = s_axi_awvalid & s_axi_wvalid & ~bvalid_reg;
   wire        lane0       = s_axi_wstrb[0];
   wire        wr_ctrl     = wr_take & (s_axi_awaddr == RSD_CTRL_ADDR);
   wire        wr_mem      = wr_take & (s_axi_awaddr == RSD_MEM_ADDR);
   wire        wr_acc      = wr_take & (s_axi_awaddr == RSD_ACC_ADDR);
   wire        wr_status   = wr_take & (s_axi_awaddr == RSD_STATUS_ADDR);
   wire        wr_count    = wr_take & (s_axi_awaddr == RSD_COUNT_ADDR);
   wire        wr_mapped   = wr_ctrl | wr_mem | wr_acc | wr_status | wr_count;
   wire        go_write    = wr_ctrl & lane0 & s_axi_wdata[RSD_GO_BIT];
   wire [7:0]  wbyte       = s_axi_wdata[7:0];

   // Read channel decode
   wire        rd_take     = s_axi_arvalid & ~rvalid_reg;
   wire        rd_ctrl     = s_axi_araddr == RSD_CTRL_ADDR;
   wire        rd_mem      = s_axi_araddr == RSD_MEM_ADDR;
   wire        rd_acc      = s_axi_araddr == RSD_ACC_ADDR;
   wire        rd_status   = s_axi_araddr == RSD_STATUS_ADDR;
   wire        rd_count    = s_axi_araddr == RSD_COUNT_ADDR;
   wire        rd_mapped   = rd_ctrl | rd_mem | rd_acc | rd_status | rd_count;
   wire [31:0] rd_value    = rd_ctrl   ? {29'h0000_0000, op_reg} :
                             rd_mem    ? {24'h00_0000, mem_reg} :
                             rd_acc    ? {24'h00_0000, accumulator_reg} :
                             rd_status ? {26'h000_0000, flags_reg} :
                             rd_count  ? {16'h0000, count_reg} : 32'h0000_0000;

   // Handshake outputs
   assign s_axi_awready = wr_take;
   assign s_axi_wready  = wr_take;
   assign s_axi_bvalid  = bvalid_reg;
   assign s_axi_bresp   = bresp_reg;
   assign s_axi_arready = rd_take;
   assign s_axi_rvalid  = rvalid_reg;
   assign s_axi_rresp   = rresp_reg;
   assign s_axi_rdata   = rdata_reg;

   ////////////////////////////////////////////////////////////////////////////////
   // Operand shorthands
   wire        c_in      = flags_reg.carry_flag;
   wire [7:0]  rotl_c    = {mem_reg[6:0], c_in};              // see RULE_01
   wire [7:0]  rotr      = {mem_reg[0], mem_reg[7:1]};        // see RULE_02 see RULE_03
   wire [7:0]  rotr_c    = {c_in, mem_reg[7:1]};              // see RULE_04 see RULE_05

   // Subtract with borrow: borrow in is the inverted carry
   wire        borrow_in = ~c_in;                                        // see RULE_06
   wire [8:0]  diff9     = {1'b0, accumulator_reg} - {1'b0, mem_reg} - {8'h00, borrow_in};
   wire [4:0]  diff5     = {1'b0, accumulator_reg[3:0]} - {1'b0, mem_reg[3:0]}
                           - {4'h0, borrow_in};
   wire [7:0]  diff      = diff9[7:0];                                   // see RULE_06
   wire        sub_c     = ~diff9[8];                                    // see RULE_07
   wire        sub_ac    = ~diff5[4];
   wire        sub_z     = (diff == 8'h00);
   wire        sub_ov    = (accumulator_reg[7] ^ mem_reg[7]) & (diff[7] ^ accumulator_reg[7]);
   wire        sub_sc    = sub_ov ^ diff[7];
   wire        sub_cz    = sub_z & flags_reg.cascade_zero_flag;

   ////////////////////////////////////////////////////////////////////////////////
   // Result selection; untouched fields hold their old values
   rsd_result_type result;
   always_comb begin
      result.acc   = accumulator_reg;
      result.mem   = mem_reg;
      result.flags = flags_reg;                                          // see RULE_09
      case (op_reg)
         RSD_OP_ROTL_CARRY_TO_ACC: begin
            result.acc              = rotl_c;                            // see RULE_01
            result.flags.carry_flag = mem_reg[7];                        // see RULE_01
         end
         RSD_OP_ROTR_IN_PLACE: begin
            result.mem = rotr;                                           // see RULE_02
         end
         RSD_OP_ROTR_TO_ACC: begin
            result.acc = rotr;                                           // see RULE_03
         end
         RSD_OP_ROTR_CARRY_IN_PLACE: begin
            result.mem              = rotr_c;                            // see RULE_04
            result.flags.carry_flag = mem_reg[0];                        // see RULE_04
         end
         RSD_OP_ROTR_CARRY_TO_ACC: begin
            result.acc              = rotr_c;                            // see RULE_05
            result.flags.carry_flag = mem_reg[0];                        // see RULE_05
         end
         RSD_OP_SUBTRACT_WITH_BORROW: begin
            result.acc                       = diff;                     // see RULE_06
            result.flags.carry_flag          = sub_c;                    // see RULE_07
            result.flags.aux_carry_flag      = sub_ac;                   // see RULE_08
            result.flags.zero_flag           = sub_z;                    // see RULE_08
            result.flags.overflow_flag       = sub_ov;                   // see RULE_08
            result.flags.signed_cascade_flag = sub_sc;                   // see RULE_08
            result.flags.cascade_zero_flag   = sub_cz;                   // see RULE_08
         end
         default: begin
            result.acc = accumulator_reg;
         end
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Next values of the software-visible registers
   wire [7:0]  mem_next   = exec_reg ? result.mem :
                            (wr_mem & lane0) ? wbyte : mem_reg;
   wire [7:0]  acc_next   = exec_reg ? result.acc :
                            (wr_acc & lane0) ? wbyte : accumulator_reg;
   wire [5:0]  flags_next = exec_reg ? result.flags :
                            (wr_status & lane0) ? wbyte[5:0] : flags_reg;
   wire [15:0] count_next = exec_reg ? count_reg + 16'h0001 :
                            wr_count ? 16'h0000 : count_reg;

   // Datapath registers; an operation runs the cycle after its go write
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         mem_reg         <= RSD_MEM_RESET;
         accumulator_reg <= RSD_ACC_RESET;
         flags_reg       <= RSD_STATUS_RESET;
         count_reg       <= RSD_COUNT_RESET;
      end else begin
         mem_reg         <= mem_next;
         accumulator_reg <= acc_next;
         flags_reg       <= flags_next;
         count_reg       <= count_next;
      end
   end

   // Opcode latch and one-cycle execute pulse
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         op_reg   <= RSD_OP_RESET;
         exec_reg <= 1'b0;
      end else begin
         if (wr_ctrl && lane0) begin
            op_reg <= wbyte[RSD_OP_MSB:RSD_OP_LSB];
         end
         exec_reg <= go_write;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Write response
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         bvalid_reg <= 1'b0;
         bresp_reg  <= RSD_RESP_OKAY;
      end else if (wr_take) begin
         bvalid_reg <= 1'b1;
         bresp_reg  <= wr_mapped ? RSD_RESP_OKAY : RSD_RESP_SLVERR;
      end else if (s_axi_bready) begin
         bvalid_reg <= 1'b0;
      end
   end

   // Read response
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rvalid_reg <= 1'b0;
         rresp_reg  <= RSD_RESP_OKAY;
         rdata_reg  <= 32'h0000_0000;
      end else if (rd_take) begin
         rvalid_reg <= 1'b1;
         rresp_reg  <= rd_mapped ? RSD_RESP_OKAY : RSD_RESP_SLVERR;
         rdata_reg  <= rd_value;
      end else if (s_axi_rready) begin
         rvalid_reg <= 1'b0;
      end
   end

endmodule

// >>> rsd_datapath_properties.sv
// Bus handshake properties of the rotate/subtract datapath
`timescale 1ns/100ps
module rsd_datapath_checker (
   input wire logic        aclk,
   input wire logic        aresetn,
   input wire logic        s_axi_awvalid,
   input wire logic        s_axi_wvalid,
   input wire logic        s_axi_awready,
   input wire logic        s_axi_wready,
   input wire logic        s_axi_bvalid,
   input wire logic        s_axi_bready,
   input wire logic [1:0]  s_axi_bresp,
   input wire logic [4:0]  s_axi_araddr,
   input wire logic        s_axi_arvalid,
   input wire logic        s_axi_arready,
   input wire logic        s_axi_rvalid,
   input wire logic        s_axi_rready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0]  s_axi_rresp
);
   import rsd_pkg::*;
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   ////////////////////////////////////////////////////////////////////////////////
   // Taking edges of a write and of a read
   sequence s_wr_take; s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid; endsequence
   sequence s_rd_take; s_axi_arvalid && !s_axi_rvalid; endsequence
   sequence s_rd_unmapped; s_rd_take ##0 (s_axi_araddr > RSD_COUNT_ADDR); endsequence
   ////////////////////////////////////////////////////////////////////////////////
   // Ready follows the valids (write: awvalid and wvalid, read: arvalid), answer one cycle later, answer stands
   property p_aw_ready; s_axi_awready == (s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid); endproperty
   a_aw_ready: assert property (p_aw_ready) else $error("awready does not follow valids");
   property p_w_ready; s_axi_wready == s_axi_awready; endproperty
   a_w_ready: assert property (p_w_ready) else $error("wready differs from awready");
   property p_b_answer; s_wr_take |=> s_axi_bvalid; endproperty
   a_b_answer: assert property (p_b_answer) else $error("no write answer after take");
   property p_b_hold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp); endproperty
   a_b_hold: assert property (p_b_hold) else $error("write answer not held");
   property p_b_release; s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid; endproperty
   a_b_release: assert property (p_b_release) else $error("write answer not released");
   property p_ar_ready; s_axi_arready == (s_axi_arvalid && !s_axi_rvalid); endproperty
   a_ar_ready: assert property (p_ar_ready) else $error("arready does not follow arvalid");
   property p_r_answer; s_rd_take |=> s_axi_rvalid ##1 (s_axi_rvalid || $past(s_axi_rready)); endproperty
   a_r_answer: assert property (p_r_answer) else $error("no read answer after take");
   property p_r_hold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata); endproperty
   a_r_hold: assert property (p_r_hold) else $error("read answer not held");
   property p_r_unmapped; s_rd_unmapped |=> s_axi_rresp == RSD_RESP_SLVERR && s_axi_rdata == 0; endproperty
   a_r_unmapped: assert property (p_r_unmapped) else $error("unmapped read not refused");
   property p_r_upper; s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000; endproperty
   a_r_upper: assert property (p_r_upper) else $error("upper read bits not zero");
endmodule
bind rsd_datapath rsd_datapath_checker u_chk (.*);

// >>> rsd_pkg.sv
// Package with register map, opcodes and flag layout of the rotate/subtract datapath
package rsd_pkg;

   ////////////////////////////////////////////////////////////////////////////////
   // Register byte addresses
   localparam logic [4:0] RSD_CTRL_ADDR   = 5'h00;
   localparam logic [4:0] RSD_MEM_ADDR    = 5'h04;
   localparam logic [4:0] RSD_ACC_ADDR    = 5'h08;
   localparam logic [4:0] RSD_STATUS_ADDR = 5'h0C;
   localparam logic [4:0] RSD_COUNT_ADDR  = 5'h10;

   ////////////////////////////////////////////////////////////////////////////////
   // Control register fields
   localparam int RSD_OP_LSB = 0;
   localparam int RSD_OP_MSB = 2;
   localparam int RSD_GO_BIT = 7;

   // Operation codes
   localparam logic [2:0] RSD_OP_ROTL_CARRY_TO_ACC   = 3'h0;
   localparam logic [2:0] RSD_OP_ROTR_IN_PLACE       = 3'h1;
   localparam logic [2:0] RSD_OP_ROTR_TO_ACC         = 3'h2;
   localparam logic [2:0] RSD_OP_ROTR_CARRY_IN_PLACE = 3'h3;
   localparam logic [2:0] RSD_OP_ROTR_CARRY_TO_ACC   = 3'h4;
   localparam logic [2:0] RSD_OP_SUBTRACT_WITH_BORROW = 3'h5;

   ////////////////////////////////////////////////////////////////////////////////
   // Status register field positions
   localparam int RSD_C_BIT  = 0;
   localparam int RSD_AC_BIT = 1;
   localparam int RSD_Z_BIT  = 2;
   localparam int RSD_OV_BIT = 3;
   localparam int RSD_SC_BIT = 4;
   localparam int RSD_CZ_BIT = 5;

   // Reset values
   localparam logic [7:0] RSD_MEM_RESET    = 8'h00;
   localparam logic [7:0] RSD_ACC_RESET    = 8'h00;
   localparam logic [5:0] RSD_STATUS_RESET = 6'h00;
   localparam logic [2:0] RSD_OP_RESET     = 3'h0;
   localparam logic [15:0] RSD_COUNT_RESET = 16'h0000;

   // AXI response codes
   localparam logic [1:0] RSD_RESP_OKAY   = 2'b00;
   localparam logic [1:0] RSD_RESP_SLVERR = 2'b10;

   ////////////////////////////////////////////////////////////////////////////////
   // Status flags, packed in register order (bit 5 down to bit 0)
   typedef struct packed {
      logic cascade_zero_flag;
      logic signed_cascade_flag;
      logic overflow_flag;
      logic zero_flag;
      logic aux_carry_flag;
      logic carry_flag;
   } rsd_flags_type;

   // One operation result: new accumulator, new memory byte, new flags
   typedef struct packed {
      logic [7:0]    acc;
      logic [7:0]    mem;
      rsd_flags_type flags;
   } rsd_result_type;

endpackage

// >>> testbench.sv
// Self-checking testbench of the rotate/subtract datapath
`timescale 1ns/100ps
module testbench;
   import rsd_pkg::*;
   logic        aclk = 0, aresetn = 0;
   logic [4:0]  s_axi_awaddr = 0, s_axi_araddr = 0;
   logic [2:0]  s_axi_awprot = 0, s_axi_arprot = 0;
   logic [31:0] s_axi_wdata = 0, s_axi_rdata;
   logic [3:0]  s_axi_wstrb = 4'hF;
   logic [1:0]  s_axi_bresp, s_axi_rresp;
   logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
   logic        s_axi_rready = 0, s_axi_awready, s_axi_wready, s_axi_bvalid;
   logic        s_axi_arready, s_axi_rvalid;
   int          fail_count = 0, n_checks = 0, n_ops = 0;
   rsd_datapath u_dut (.*);
   // Free-running clock
   always #25 aclk = ~aclk;
   ////////////////////////////////////////////////////////////////////////////////
   // Verdict and end of run
   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", n_checks, fail_count);
      if (fail_count == 0 && n_checks > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   task automatic check(input string nm, input logic [31:0] e, input logic [31:0] g);
      n_checks++;
      if (g !== e) begin
         fail_count++;
         $display("Error %s expected %h seen %h", nm, e, g);
      end
   endtask
   // Bounded wait for a handshake signal sampled high at a rising edge
   task automatic wait_hi(ref logic s);
      int i;
      i = 0;
      do begin
         @(posedge aclk);
         i++;
      end while (s !== 1'b1 && i < 40);
      if (s !== 1'b1) begin
         fail_count++;
         report_and_stop;
      end
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   // Bus cycles, response ready raised late so the answer must stand
   task automatic axi_wr(input logic [4:0] a, input logic [31:0] d, input logic [1:0] er);
      s_axi_awaddr  <= a;
      s_axi_wdata   <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid  <= 1'b1;
      wait_hi(s_axi_awready);
      s_axi_awvalid <= 1'b0;
      s_axi_wvalid  <= 1'b0;
      wait_hi(s_axi_bvalid);
      s_axi_bready <= 1'b1;
      @(posedge aclk);
      s_axi_bready <= 1'b0;
      check("bresp", 32'(er), 32'(s_axi_bresp));
   endtask
   task automatic rd_chk(input string nm, input logic [4:0] a, input logic [31:0] e,
                         input logic [1:0] er);
      s_axi_araddr  <= a;
      s_axi_arvalid <= 1'b1;
      wait_hi(s_axi_arready);
      s_axi_arvalid <= 1'b0;
      wait_hi(s_axi_rvalid);
      s_axi_rready <= 1'b1;
      @(posedge aclk);
      s_axi_rready <= 1'b0;
      check(nm, e, s_axi_rdata);
      check("rresp", 32'(er), 32'(s_axi_rresp));
   endtask
   // Load operands, start one operation, read back all results
   task automatic run_op(input logic [2:0] op, input logic [7:0] m, a, input logic [5:0] f,
                         input logic [7:0] em, ea, input logic [5:0] ef);
      axi_wr(RSD_MEM_ADDR, {24'h00_0000, m}, RSD_RESP_OKAY);
      axi_wr(RSD_ACC_ADDR, {24'h00_0000, a}, RSD_RESP_OKAY);
      axi_wr(RSD_STATUS_ADDR, {26'h000_0000, f}, RSD_RESP_OKAY);
      axi_wr(RSD_CTRL_ADDR, {24'h00_0000, 5'h10, op}, RSD_RESP_OKAY);
      n_ops++;
      rd_chk("acc", RSD_ACC_ADDR, {24'h00_0000, ea}, RSD_RESP_OKAY);
      rd_chk("mem", RSD_MEM_ADDR, {24'h00_0000, em}, RSD_RESP_OKAY);
      rd_chk("flags", RSD_STATUS_ADDR, {26'h000_0000, ef}, RSD_RESP_OKAY);
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   // Scenarios
   task automatic t_reset;
      logic [4:0] ad[5] = '{RSD_CTRL_ADDR, RSD_MEM_ADDR, RSD_ACC_ADDR, RSD_STATUS_ADDR,
                            RSD_COUNT_ADDR};
      foreach (ad[k]) rd_chk("reset value", ad[k], 32'h0000_0000, RSD_RESP_OKAY);
      $display("done reset values");
   endtask
   // Both carry values, other flags opposite to carry so a leak shows
   task automatic t_rotates;
      logic [7:0] m, a;
      logic [5:0] f;
      for (int k = 0; k < 2; k++) begin
         m = k ? 8'h5A : 8'hA5;
         f = k ? 6'h01 : 6'h3E;
         a = 8'h33;
         run_op(RSD_OP_ROTL_CARRY_TO_ACC, m, a, f, m, {m[6:0], f[0]}, {f[5:1], m[7]});
         run_op(RSD_OP_ROTR_IN_PLACE, m, a, f, {m[0], m[7:1]}, a, f);
         run_op(RSD_OP_ROTR_TO_ACC, m, a, f, m, {m[0], m[7:1]}, f);
         run_op(RSD_OP_ROTR_CARRY_IN_PLACE, m, a, f, {f[0], m[7:1]}, a, {f[5:1], m[0]});
         run_op(RSD_OP_ROTR_CARRY_TO_ACC, m, a, f, m, {f[0], m[7:1]}, {f[5:1], m[0]});
         run_op(3'h6, m, a, f, m, a, f);
      end
      $display("done rotates");
   endtask
   // Positive, negative, signed overflow and zero with cascaded zero
   task automatic t_subtract;
      logic [7:0] av[4] = '{8'h50, 8'h20, 8'h80, 8'h10};
      logic [7:0] mv[4] = '{8'h20, 8'h50, 8'h01, 8'h0F};
      logic [5:0] fv[4] = '{6'h01, 6'h00, 6'h01, 6'h20};
      logic [8:0] d;
      logic [4:0] l;
      rsd_flags_type e;
      for (int k = 0; k < 4; k++) begin
         d = {1'b0, av[k]} - mv[k] - !fv[k][0];
         l = {1'b0, av[k][3:0]} - mv[k][3:0] - !fv[k][0];
         e.carry_flag = !d[8];
         e.aux_carry_flag = !l[4];
         e.zero_flag = (d[7:0] == 8'h00);
         e.overflow_flag = (av[k][7] != mv[k][7]) && (d[7] != av[k][7]);
         e.signed_cascade_flag = e.overflow_flag ^ d[7];
         e.cascade_zero_flag = e.zero_flag & fv[k][5];
         run_op(RSD_OP_SUBTRACT_WITH_BORROW, mv[k], av[k], fv[k], mv[k], d[7:0], e);
      end
      $display("done subtract");
   endtask
   task automatic t_tail;
      rd_chk("count", RSD_COUNT_ADDR, 32'(n_ops), RSD_RESP_OKAY);
      rd_chk("ctrl", RSD_CTRL_ADDR, {29'h0000_0000, RSD_OP_SUBTRACT_WITH_BORROW}, RSD_RESP_OKAY);
      axi_wr(RSD_COUNT_ADDR, 32'h0000_0000, RSD_RESP_OKAY);
      rd_chk("count", RSD_COUNT_ADDR, 32'h0000_0000, RSD_RESP_OKAY);
      axi_wr(5'h14, 32'h0000_00FF, RSD_RESP_SLVERR);
      rd_chk("unmapped", 5'h14, 32'h0000_0000, RSD_RESP_SLVERR);
      $display("done count and unmapped");
   endtask
   // Reset for 8 cycles, then the scenarios in turn
   initial begin
      repeat (8) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      t_reset;
      t_rotates;
      t_subtract;
      t_tail;
      report_and_stop;
   end
endmodule
